//--- include/acpw_pkg.sv
// Shared constants and types for the ancillary and control port writer.
package acpw_pkg;

	// Register addresses on the ten-bit port.
	localparam logic [7:0] REG_TEST   = 8'h0D;
	localparam logic [7:0] REG_MAP0   = 8'h0F;
	localparam logic [7:0] REG_ANCCTL = 8'h18;

	// Reset values; pin 2 carries the H-bit, 4 lock, 7 the TPG enable.
	localparam logic [7:0]  TEST_RST   = 8'h00;
	localparam logic [7:0]  ANCCTL_RST = 8'h00;
	localparam logic [47:0] MAP_RST    = 48'h8000_1101_2000;

	// Field positions.
	localparam int TEST_TPGEN   = 6;
	localparam int ANCCTL_CSAPP = 0;

	// Port framing codes on the two upper port bits.
	localparam logic [1:0] HDR_ADDR = 2'h0;
	localparam logic [1:0] HDR_DATA = 2'h3;

	// Port clocks needed after reset before the port listens.
	localparam logic [1:0] INIT_CLKS = 2'h3;

	// Ancillary data flag words.
	localparam logic [9:0] ADF0 = 10'h000;
	localparam logic [9:0] ADF1 = 10'h3FF;

	// Pin mapping codes: 1xh drive the pin, 2xh sample it.
	localparam logic [5:0] MAP_CRC  = 6'h10;
	localparam logic [5:0] MAP_LOCK = 6'h11;
	localparam logic [5:0] MAP_HBIT = 6'h12;
	localparam logic [5:0] MAP_OVF  = 6'h13;
	localparam logic [5:0] MAP_TPGQ = 6'h14;
	localparam logic [5:0] MAP_TPGI = 6'h20;
	localparam logic [5:0] MAP_CSAI = 6'h21;

	// Pin count and ancillary FIFO geometry.
	localparam int NPIN = 8;
	localparam int FAW  = 3;

	// One FIFO entry: start-of-packet mark and the word.
	typedef struct packed {
		logic       sop;
		logic [9:0] word;
	} acpw_anc_t;

	// Control write phase.
	typedef enum logic [1:0] {
		PH_ADDR = 2'b01,
		PH_DATA = 2'b10
	} acpw_phase_t;

	// Inserter state.
	typedef enum logic [2:0] {
		INS_IDLE = 3'b001,
		INS_FLAG = 3'b010,
		INS_DATA = 3'b100
	} acpw_ins_t;

endpackage

//--- logic/acpw_sync.sv
// Two flip-flop synchroniser for a bundle of levels.
`timescale 1ns/100ps
`default_nettype none
module acpw_sync #(
	parameter int W = 1
) (
	// Destination clock and reset.
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Level in, synchronised level out.
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;   // First stage, read only by the second.

	// Both stages clear on reset and shift every rising edge.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule
`default_nettype wire

//--- logic/acpw_anc_inserter.sv
// Prepends the flag words and releases FIFO words in the allowed slots.
`timescale 1ns/100ps
`default_nettype none
module acpw_anc_inserter (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst_b,
	// FIFO head.
	input  wire acpw_pkg::acpw_anc_t head,
	input  wire logic             headValid,
	output logic                  pop,
	// Insertion slot and output word.
	input  wire logic             insertOk,
	output logic                  ancValid,
	output logic [9:0]            ancWord
);
	acpw_pkg::acpw_ins_t ins_r, ins_nxt;   // Sequence state.
	logic [1:0] cnt_r, cnt_nxt;            // Flag word counter.
	logic first_r, first_nxt;              // Leading word still due.
	logic vld_nxt;
	logic [9:0] word_nxt;

	// Each packet opens with the three flag words, then its entries.
	always_comb begin
		ins_nxt   = ins_r;
		cnt_nxt   = cnt_r;
		first_nxt = first_r;
		vld_nxt   = 1'b0;
		word_nxt  = ancWord;
		pop       = 1'b0;
		case (ins_r)
			acpw_pkg::INS_IDLE: begin
				if (headValid && insertOk) begin
					ins_nxt   = acpw_pkg::INS_FLAG;
					cnt_nxt   = 2'h0;
					first_nxt = 1'b1;
				end
			end
			acpw_pkg::INS_FLAG: begin
				if (insertOk) begin
					vld_nxt  = 1'b1;
					word_nxt = (cnt_r == 2'h0) ? acpw_pkg::ADF0
						: acpw_pkg::ADF1;
					cnt_nxt  = cnt_r + 2'h1;
					if (cnt_r == 2'h2) begin
						ins_nxt = acpw_pkg::INS_DATA;
					end
				end
			end
			acpw_pkg::INS_DATA: begin
				// A new packet head waits for its own flag words.
				if (headValid && head.sop && !first_r) begin
					ins_nxt = acpw_pkg::INS_IDLE;
				end else if (headValid && insertOk) begin
					pop       = 1'b1;
					vld_nxt   = 1'b1;
					word_nxt  = head.word;
					first_nxt = 1'b0;
				end
			end
			default: ins_nxt = acpw_pkg::INS_IDLE;
		endcase
	end

	// State and output word registers.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ins_r    <= acpw_pkg::INS_IDLE;
			cnt_r    <= 2'h0;
			first_r  <= 1'b0;
			ancValid <= 1'b0;
			ancWord  <= 10'h000;
		end else begin
			ins_r    <= ins_nxt;
			cnt_r    <= cnt_nxt;
			first_r  <= first_nxt;
			ancValid <= vld_nxt;
			ancWord  <= word_nxt;
		end
	end

	a_flag_lead: assert property (
		@(posedge clk) disable iff (!rst_b)
		(ins_r == acpw_pkg::INS_FLAG && ins_nxt == acpw_pkg::INS_DATA)
		|=> ancValid && ancWord == acpw_pkg::ADF1
		&& $past(ancWord) == acpw_pkg::ADF1)
		else $error("flag sequence did not end in two ones words");
	a_insert_gate: assert property (
		@(posedge clk) disable iff (!rst_b)
		ancValid |-> $past(insertOk))
		else $error("ancillary word sent outside an allowed slot");
endmodule
`default_nettype wire

//--- logic/acpw_port_writer.sv
// Ancillary and control port: register writes, ancillary FIFO, I/O map.
//
// Summary of operation
// - Target low, direction low: register write.
// - Address latched on port clock rise.
// - Next rise under code 11 stores the data byte.
// - Target high, direction low: FIFO loading.
// - Words in packet order from DID.
// - Only ancillary and flush clocks write the FIFO.
// - No FIFO read path through port.
// - Checksum from host or device-appended.
// - Flag sequence prepended to every packet.
// - H-bit offered on I/O pin 2.
// - Insert in SD blanking, HD chroma.
// - Eight 6-bit maps steer I/O pins.
// - Pin-written bits apply on port clock.
// - Pin 0 map at 0Fh.
// - Test pattern register at 0Dh.
// - Lock indicator on pin 4 after reset.
`timescale 1ns/100ps
`default_nettype none
module acpw_port_writer (
	// Video clock domain.
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Port clock and port bus, all timed to the port clock.
	input  wire logic       portClk,
	input  wire logic [9:0] adIn,
	input  wire logic       portTargetSel,
	input  wire logic       rdWrSel,
	// Multi-function I/O pins.
	input  wire logic [7:0] mfIn,
	output logic      [7:0] mfOut,
	output logic      [7:0] mfOe,
	// Status from the video core.
	input  wire logic       hBit,
	input  wire logic       lockDetect,
	input  wire logic       crcLumaErr,
	input  wire logic       hdMode,
	input  wire logic       sdBlank,
	input  wire logic       hdChromaSlot,
	// Test pattern control to the generator.
	output logic      [7:0] testPattern,
	// Ancillary words toward the video multiplexer.
	output logic            ancValid,
	output logic      [9:0] ancWord
);
	localparam int FAWP = acpw_pkg::FAW;   // FIFO address bits.
	// ---- Port clock domain state ----
	acpw_pkg::acpw_phase_t phase_r, phase_nxt;   // Write phase.
	logic [1:0] init_r, init_nxt;                // Wake-up clocks seen.
	logic [7:0] addr_r, addr_nxt;                // Latched address.
	logic [7:0] wrAddr_r, wrAddr_nxt;            // Held write address.
	logic [7:0] wrData_r, wrData_nxt;            // Held write data.
	logic wrTgl_r, wrTgl_nxt;                    // Write event toggle.
	logic pcTgl_r, pcTgl_nxt;                    // Port clock toggle.
	acpw_pkg::acpw_anc_t s1_r, s1_nxt;           // First buffer stage.
	acpw_pkg::acpw_anc_t s2_r, s2_nxt;           // Second buffer stage.
	logic s1v_r, s1v_nxt, s2v_r, s2v_nxt;        // Stage occupancy.
	logic [8:0] idx_r, idx_nxt;                  // Word index in packet.
	logic [7:0] dc_r, dc_nxt;                    // Data count word.
	logic [8:0] sum_r, sum_nxt;                  // Running checksum.
	logic [9:0] cs_r, cs_nxt;                    // Checksum to append.
	logic csPend_r, csPend_nxt;                  // Append due.
	logic [FAWP:0] wrBin_r, wrBin_nxt;           // Write pointer.
	logic ovf_r, ovf_nxt;                        // Sticky overflow.
	acpw_pkg::acpw_anc_t mem_r [2**acpw_pkg::FAW];   // FIFO storage.
	logic ctlMode, ancMode, flushClk, ready, step, fifoWr, full;
	logic [7:0] dcNow;
	logic [8:0] sumNow;
	logic lastUdw;
	logic [FAWP:0] rdGp, wrG_r, wrG_nxt;   // Read pointer seen here, own gray.
	logic appendP;               // Append setting seen here.

	// ---- Video clock domain state ----
	logic [7:0] test_r, test_nxt;                     // Test pattern.
	logic [7:0] ancCtl_r, ancCtl_nxt;                 // Ancillary control.
	logic [5:0] map_r [acpw_pkg::NPIN];               // Pin maps.
	logic [5:0] map_nxt [acpw_pkg::NPIN];
	logic [7:0] mfOut_nxt, mfOe_nxt;
	logic wrTglS, wrTglD_r, pcTglS, pcTglD_r, ovfS;
	logic [7:0] mfS;                                  // Pins, synchronised.
	logic [FAWP:0] wrGv, rdBin_r, rdBin_nxt, rdG_r, rdG_nxt;
	logic wrEv, pcEv, empty, pop, insertOk;

	// Crossings: gray pointers leave flops, so no glitch is sampled.
	acpw_sync #(.W(FAWP + 1)) u_rdSync (.clk(portClk), .rst_b(rst_b),
		.d(rdG_r), .q(rdGp));
	acpw_sync #(.W(1)) u_apSync (.clk(portClk), .rst_b(rst_b),
		.d(ancCtl_r[acpw_pkg::ANCCTL_CSAPP]), .q(appendP));
	acpw_sync #(.W(FAWP + 12)) u_vSync (.clk(clk), .rst_b(rst_b),
		.d({wrG_r, wrTgl_r, pcTgl_r, ovf_r, mfIn}),
		.q({wrGv, wrTglS, pcTglS, ovfS, mfS}));

	// Port side: decode the bus on every port clock rise.
	always_comb begin
		phase_nxt  = phase_r;
		init_nxt   = init_r;
		addr_nxt   = addr_r;
		wrAddr_nxt = wrAddr_r;
		wrData_nxt = wrData_r;
		wrTgl_nxt  = wrTgl_r;
		pcTgl_nxt  = ~pcTgl_r;
		s1_nxt = s1_r;
		s2_nxt = s2_r;
		s1v_nxt = s1v_r;
		s2v_nxt = s2v_r;
		idx_nxt = idx_r;
		dc_nxt  = dc_r;
		sum_nxt = sum_r;
		cs_nxt  = cs_r;
		csPend_nxt = csPend_r;
		wrBin_nxt  = wrBin_r;
		ovf_nxt    = ovf_r;
		ctlMode  = !portTargetSel && !rdWrSel;
		ancMode  = portTargetSel && !rdWrSel;
		flushClk = portTargetSel && rdWrSel;
		ready = (init_r == acpw_pkg::INIT_CLKS);
		step  = ready && (ancMode || flushClk);
		full  = (wrG_r == {~rdGp[FAWP:FAWP-1], rdGp[FAWP-2:0]});
		fifoWr = step && s2v_r && !full;
		dcNow  = (idx_r == 9'h002) ? adIn[7:0] : dc_r;
		sumNow = ((idx_r == 9'h000) ? 9'h000 : sum_r) + adIn[8:0];
		lastUdw = (idx_r >= 9'h002) && (idx_r == {1'b0, dcNow} + 9'h002);
		if (!ready) begin
			// The port listens only after the wake-up clocks.
			init_nxt = init_r + 2'h1;
		end else if (ctlMode) begin
			case (phase_r)
				acpw_pkg::PH_ADDR: begin
					if (adIn[9:8] == acpw_pkg::HDR_ADDR) begin
						addr_nxt  = adIn[7:0];
						phase_nxt = acpw_pkg::PH_DATA;
					end
				end
				acpw_pkg::PH_DATA: begin
					if (adIn[9:8] == acpw_pkg::HDR_DATA) begin
						wrAddr_nxt = addr_r;
						wrData_nxt = adIn[7:0];
						wrTgl_nxt  = ~wrTgl_r;
						phase_nxt  = acpw_pkg::PH_ADDR;
					end
				end
				default: phase_nxt = acpw_pkg::PH_ADDR;
			endcase
		end else begin
			phase_nxt = acpw_pkg::PH_ADDR;
		end
		if (step) begin
			// Two stages in front of the FIFO; each ancillary or flush rise moves them.
			if (s2v_r && full) begin
				ovf_nxt = 1'b1;
			end
			if (fifoWr) begin
				wrBin_nxt = wrBin_r + 1'b1;
			end
			s2_nxt  = s1_r;
			s2v_nxt = s1v_r;
			s1v_nxt = 1'b0;
			if (csPend_r) begin
				// Device checksum takes this clock; bus is ignored.
				s1_nxt  = '{sop: 1'b0, word: cs_r};
				s1v_nxt = 1'b1;
				csPend_nxt = 1'b0;
			end else if (ancMode) begin
				s1_nxt  = '{sop: idx_r == 9'h000, word: adIn};
				s1v_nxt = 1'b1;
				sum_nxt = sumNow;
				dc_nxt  = dcNow;
				idx_nxt = idx_r + 9'h001;
				if (lastUdw && appendP) begin
					cs_nxt     = {~sumNow[8], sumNow};
					csPend_nxt = 1'b1;
					idx_nxt    = 9'h000;
				end else if (idx_r == {1'b0, dc_r} + 9'h003
					&& idx_r >= 9'h003) begin
					idx_nxt = 9'h000;   // Host checksum ends it.
				end
			end
		end
		wrG_nxt = wrBin_nxt ^ (wrBin_nxt >> 1);
	end

	// Port side registers.
	always_ff @(posedge portClk or negedge rst_b) begin
		if (!rst_b) begin
			phase_r <= acpw_pkg::PH_ADDR;
			init_r  <= 2'h0;
			addr_r  <= 8'h00;
			wrAddr_r <= 8'h00;
			wrData_r <= 8'h00;
			wrTgl_r <= 1'b0;
			pcTgl_r <= 1'b0;
			s1_r <= '0;
			s2_r <= '0;
			s1v_r <= 1'b0;
			s2v_r <= 1'b0;
			idx_r <= 9'h000;
			dc_r  <= 8'h00;
			sum_r <= 9'h000;
			cs_r  <= 10'h000;
			csPend_r <= 1'b0;
			wrBin_r  <= '0;
			wrG_r    <= '0;
			ovf_r    <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			init_r  <= init_nxt;
			addr_r  <= addr_nxt;
			wrAddr_r <= wrAddr_nxt;
			wrData_r <= wrData_nxt;
			wrTgl_r <= wrTgl_nxt;
			pcTgl_r <= pcTgl_nxt;
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s1v_r <= s1v_nxt;
			s2v_r <= s2v_nxt;
			idx_r <= idx_nxt;
			dc_r  <= dc_nxt;
			sum_r <= sum_nxt;
			cs_r  <= cs_nxt;
			csPend_r <= csPend_nxt;
			wrBin_r  <= wrBin_nxt;
			wrG_r    <= wrG_nxt;
			ovf_r    <= ovf_nxt;
		end
	end

	// FIFO storage is written only from the port side; no reset needed.
	always_ff @(posedge portClk) begin
		if (fifoWr) begin
			mem_r[wrBin_r[FAWP-1:0]] <= s2_r;
		end
	end

	// Video side: apply crossed writes, pin inputs and pin outputs.
	always_comb begin
		wrEv = wrTglS ^ wrTglD_r;
		pcEv = pcTglS ^ pcTglD_r;
		test_nxt   = test_r;
		ancCtl_nxt = ancCtl_r;
		map_nxt    = map_r;
		if (wrEv) begin
			if (wrAddr_r == acpw_pkg::REG_TEST) begin
				test_nxt = wrData_r;
			end
			if (wrAddr_r == acpw_pkg::REG_ANCCTL) begin
				ancCtl_nxt = wrData_r;
			end
		end
		for (int i = 0; i < acpw_pkg::NPIN; i++) begin
			if (wrEv && wrAddr_r == acpw_pkg::REG_MAP0 + 8'(i)) begin
				map_nxt[i] = wrData_r[5:0];
			end
			// Pin-driven bits land only when a port clock has come.
			if (pcEv && map_r[i] == acpw_pkg::MAP_TPGI) begin
				test_nxt[acpw_pkg::TEST_TPGEN] = mfS[i];
			end
			if (pcEv && map_r[i] == acpw_pkg::MAP_CSAI) begin
				ancCtl_nxt[acpw_pkg::ANCCTL_CSAPP] = mfS[i];
			end
			// Output codes drive the pin with the chosen status bit.
			mfOe_nxt[i] = (map_r[i][5:4] == 2'h1);
			case (map_r[i])
				acpw_pkg::MAP_CRC:  mfOut_nxt[i] = crcLumaErr;
				acpw_pkg::MAP_LOCK: mfOut_nxt[i] = lockDetect;
				acpw_pkg::MAP_HBIT: mfOut_nxt[i] = hBit;
				acpw_pkg::MAP_OVF:  mfOut_nxt[i] = ovfS;
				acpw_pkg::MAP_TPGQ:
					mfOut_nxt[i] = test_r[acpw_pkg::TEST_TPGEN];
				default: mfOut_nxt[i] = 1'b0;
			endcase
		end
		empty     = (rdG_r == wrGv);
		rdBin_nxt = pop ? rdBin_r + 1'b1 : rdBin_r;
		rdG_nxt   = rdBin_nxt ^ (rdBin_nxt >> 1);
		insertOk  = hdMode ? hdChromaSlot : sdBlank;
	end

	// Video side registers.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			test_r   <= acpw_pkg::TEST_RST;
			ancCtl_r <= acpw_pkg::ANCCTL_RST;
			for (int i = 0; i < acpw_pkg::NPIN; i++) begin
				map_r[i] <= acpw_pkg::MAP_RST[i*6 +: 6];
			end
			wrTglD_r <= 1'b0;
			pcTglD_r <= 1'b0;
			mfOut    <= 8'h00;
			mfOe     <= 8'h00;
			rdBin_r  <= '0;
			rdG_r    <= '0;
		end else begin
			test_r   <= test_nxt;
			ancCtl_r <= ancCtl_nxt;
			map_r    <= map_nxt;
			wrTglD_r <= wrTglS;
			pcTglD_r <= pcTglS;
			mfOut    <= mfOut_nxt;
			mfOe     <= mfOe_nxt;
			rdBin_r  <= rdBin_nxt;
			rdG_r    <= rdG_nxt;
		end
	end

	assign testPattern = test_r;

	// Packet sequencer; reads the FIFO head only here, never the port.
	acpw_anc_inserter u_ins (
		.clk(clk),
		.rst_b(rst_b),
		.head(mem_r[rdBin_r[FAWP-1:0]]),
		.headValid(!empty),
		.pop(pop),
		.insertOk(insertOk),
		.ancValid(ancValid),
		.ancWord(ancWord)
	);

	a_addr_phase: assert property (
		@(posedge portClk) disable iff (!rst_b)
		(ready && ctlMode && phase_r == acpw_pkg::PH_ADDR
		&& adIn[9:8] == acpw_pkg::HDR_ADDR)
		|=> phase_r == acpw_pkg::PH_DATA && addr_r == $past(adIn[7:0]))
		else $error("address not latched on port clock");
	a_ctl_nofifo: assert property (
		@(posedge portClk) disable iff (!rst_b)
		ctlMode |=> wrBin_r == $past(wrBin_r) && !s1v_r)
		else $error("control traffic reached the FIFO");
	a_data_store: assert property (   // A mapped pin may own bit 6.
		@(posedge clk) disable iff (!rst_b)
		(wrEv && wrAddr_r == acpw_pkg::REG_TEST)
		|=> ((test_r ^ $past(wrData_r)) & 8'hBF) == 8'h00)
		else $error("test pattern write not stored");
	a_map_store: assert property (
		@(posedge clk) disable iff (!rst_b)
		(wrEv && wrAddr_r == acpw_pkg::REG_MAP0)
		|=> map_r[0] == $past(wrData_r[5:0]))
		else $error("pin 0 map write not stored");
	a_lock_pin: assert property (
		@(posedge clk) disable iff (!rst_b)
		map_r[4] == acpw_pkg::MAP_LOCK
		|=> mfOe[4] && mfOut[4] == $past(lockDetect))
		else $error("lock indicator not on pin 4");
	a_ovf_flag: assert property (
		@(posedge portClk) disable iff (!rst_b)
		(step && s2v_r && full)
		|=> ovf_r && wrBin_r == $past(wrBin_r))
		else $error("full FIFO overwritten or not flagged");
	a_cs_append: assert property (
		@(posedge portClk) disable iff (!rst_b)
		(step && csPend_r)
		|=> s1v_r && s1_r.word == $past(cs_r) ##1 s2_r.word == $past(cs_r, 2))
		else $error("appended checksum lost");
	a_pin_input: assert property (
		@(posedge clk) disable iff (!rst_b)
		(!pcEv && !wrEv)
		|=> test_r == $past(test_r) && ancCtl_r == $past(ancCtl_r))
		else $error("pin input applied without a port clock");
endmodule
`default_nettype wire

//--- dv/acpw_host_model.sv
// Host controller model that drives the ancillary and control port.
`timescale 1ns/100ps
`default_nettype none
module acpw_host_model (
	// Port clock and port bus toward the device.
	output logic       portClk,
	output logic [9:0] adIn,
	output logic       portTargetSel,
	output logic       rdWrSel
);
	// Idle port clock periods after each transfer; raised for a slow host.
	int gap = 0;

	// The port clock stands low and the pulled-down bus reads zero.
	initial begin
		portClk = 1'b0;
		adIn = 10'h000;
		portTargetSel = 1'b0;
		rdWrSel = 1'b0;
	end

	// One 32 ns port clock, never faster than the video clock; the word
	// is set up before the rise and withdrawn at the fall.
	task automatic cyc(input logic tgt, input logic rw,
		input logic [9:0] w);
		portTargetSel = tgt;
		rdWrSel = rw;
		adIn = w;
		#13 portClk = 1'b1;
		#16 portClk = 1'b0;
		adIn = 10'h000;
		#(3 + 32 * gap);
	endtask

	// Wake-up clocks that the port needs after reset.
	task automatic wake();
		repeat (3) cyc(1'b0, 1'b0, 10'h000);
	endtask

	// Control write: address under code 00, then data under code 11.
	task automatic regWr(input logic [7:0] a, input logic [7:0] d);
		cyc(1'b0, 1'b0, {2'b00, a});
		cyc(1'b0, 1'b0, {2'b11, d});
	endtask

	// Ancillary words in packet order from the DID, one per rise.
	task automatic anc(input logic [9:0] w[$]);
		foreach (w[i]) cyc(1'b1, 1'b0, w[i]);
	endtask

	// Two extra rises push the last word through the pipeline.
	task automatic flush();
		repeat (2) cyc(1'b1, 1'b1, 10'h000);
	endtask
endmodule
`default_nettype wire

//--- dv/acpw_port_writer_bench.sv
// Self-checking bench for the ancillary and control port writer.
`timescale 1ns/100ps
`default_nettype none
module acpw_port_writer_bench;
	// Video clock domain, status levels and pin inputs.
	logic       clk;
	logic       rst_b;
	logic       hBit;
	logic       lockDetect;
	logic       crcLumaErr;
	logic       hdMode;
	logic       sdBlank;
	logic       hdChromaSlot;
	logic [7:0] mfIn;
	// Port signals from the host model.
	logic       portClk;
	logic [9:0] adIn;
	logic       portTargetSel;
	logic       rdWrSel;
	// Device outputs.
	logic [7:0] mfOut;
	logic [7:0] mfOe;
	logic [7:0] testPattern;
	logic       ancValid;
	logic [9:0] ancWord;
	// Counters, emitted words and scratch packets.
	int         n_errors = 0;
	int         comparisons = 0;
	logic [9:0] got[$];
	logic [9:0] pkt[$];
	logic [9:0] e[$];

	acpw_host_model i_acpw_host_model (
		.portClk       (portClk),
		.adIn          (adIn),
		.portTargetSel (portTargetSel),
		.rdWrSel       (rdWrSel)
	);

	acpw_port_writer i_acpw_port_writer (
		.clk           (clk),
		.rst_b         (rst_b),
		.portClk       (portClk),
		.adIn          (adIn),
		.portTargetSel (portTargetSel),
		.rdWrSel       (rdWrSel),
		.mfIn          (mfIn),
		.mfOut         (mfOut),
		.mfOe          (mfOe),
		.hBit          (hBit),
		.lockDetect    (lockDetect),
		.crcLumaErr    (crcLumaErr),
		.hdMode        (hdMode),
		.sdBlank       (sdBlank),
		.hdChromaSlot  (hdChromaSlot),
		.testPattern   (testPattern),
		.ancValid      (ancValid),
		.ancWord       (ancWord)
	);

	// Video clock with an 8 ns period.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Collect every word that the inserter emits.
	always @(posedge clk) begin
		if (ancValid === 1'b1)
			got.push_back(ancWord);
	end

	// Compares one value and counts the outcome.
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then stops the run.
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Waits a number of video clock edges.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Checksum over DID to last user word: 9-bit sum, bit 9 inverted.
	function automatic logic [9:0] csum(input logic [9:0] w[$]);
		logic [8:0] s;
		s = 9'h000;
		foreach (w[i]) s = s + w[i][8:0];
		return {~s[8], s};
	endfunction

	// Waits, bounded, for flag words plus packet and compares them all.
	task automatic expectPkt(input logic [9:0] w[$]);
		e = {acpw_pkg::ADF0, acpw_pkg::ADF1, acpw_pkg::ADF1, w};
		for (int i = 0; i < 2000 && got.size() < e.size(); i++)
			@(posedge clk);
		if (got.size() < e.size()) begin
			check("ancCount", got.size(), e.size());
			conclude();
		end else begin
			foreach (e[k])
				check("ancWord", got[k], e[k]);
			got.delete();
		end
	endtask

	initial begin
		rst_b = 1'b0;
		{hBit, lockDetect, crcLumaErr, hdMode} = 4'h0;
		{sdBlank, hdChromaSlot} = 2'h0;
		mfIn = 8'h00;
		// One port clock also rises while reset is held.
		fork
			i_acpw_host_model.cyc(1'b0, 1'b0, 10'h000);
		join_none
		tick(4);
		rst_b <= 1'b1;
		tick(3);
		check("testPattern", testPattern, acpw_pkg::TEST_RST);
		check("mfOe", mfOe, 8'h14);
		for (int v = 0; v < 2; v++) begin
			hBit <= v[0];
			lockDetect <= !v[0];
			tick(4);
			check("hBitPin", mfOut[2], v[0]);
			check("lockPin", mfOut[4], !v[0]);
		end
		$display("test reset_defaults done");

		// Register writes, a wrong data code and an unmapped address.
		i_acpw_host_model.wake();
		i_acpw_host_model.regWr(acpw_pkg::REG_TEST, 8'h27);
		tick(6);
		check("testPattern", testPattern, 8'h27);
		i_acpw_host_model.cyc(1'b0, 1'b0, 10'h00D);
		i_acpw_host_model.cyc(1'b0, 1'b0, 10'h155);
		tick(6);
		check("testPattern", testPattern, 8'h27);
		i_acpw_host_model.cyc(1'b0, 1'b0, 10'h305);
		i_acpw_host_model.regWr(8'h40, 8'hFF);
		tick(6);
		check("testPattern", testPattern, 8'h05);
		check("ancCount", got.size(), 16'h0000);
		$display("test control_writes done");

		// Pin 0 carries the luma CRC error; pin 7 drives TPG enable.
		i_acpw_host_model.regWr(acpw_pkg::REG_MAP0, 8'h10);
		for (int v = 0; v < 2; v++) begin
			crcLumaErr <= v[0];
			tick(6);
			check("crcPin", mfOut[0], v[0]);
			check("crcPinOe", mfOe[0], 1'b1);
		end
		// Pin 3 reads the TPG enable bit back as an output.
		i_acpw_host_model.regWr(acpw_pkg::REG_MAP0 + 8'h03,
			{2'b00, acpw_pkg::MAP_TPGQ});
		for (int v = 1; v >= 0; v--) begin
			mfIn <= {v[0], 7'h00};
			tick(8);
			check("tpgEnable", testPattern[6], !v[0]);
			i_acpw_host_model.flush();
			tick(6);
			check("tpgEnable", testPattern[6], v[0]);
			check("tpgPin", mfOut[3], v[0]);
		end
		$display("test io_map done");

		// SD packet with host checksum, held until a blanking slot.
		pkt = {10'h161, 10'h101, 10'h102, 10'h0AA, 10'h155};
		pkt.push_back(csum(pkt));
		i_acpw_host_model.anc(pkt);
		i_acpw_host_model.flush();
		tick(6);
		check("ancCount", got.size(), 16'h0000);
		sdBlank <= 1'b1;
		expectPkt(pkt);
		$display("test anc_sd done");

		// HD packet from a slow host, checksum made by the device.
		i_acpw_host_model.regWr(acpw_pkg::REG_ANCCTL, 8'h01);
		tick(1);
		hdMode <= 1'b1;
		i_acpw_host_model.gap = 2;
		pkt = {10'h162, 10'h101, 10'h101, 10'h2C3};
		i_acpw_host_model.anc(pkt);
		// The bus is ignored on the rise that loads the checksum.
		i_acpw_host_model.cyc(1'b1, 1'b0, 10'h3FF);
		i_acpw_host_model.flush();
		pkt.push_back(csum(pkt));
		tick(10);
		check("ancCount", got.size(), 16'h0000);
		hdChromaSlot <= 1'b1;
		expectPkt(pkt);
		$display("test anc_hd_append done");

		// Overfill the FIFO with no slot open; overflow shows on pin 1.
		i_acpw_host_model.gap = 0;
		i_acpw_host_model.regWr(acpw_pkg::REG_ANCCTL, 8'h00);
		tick(1);
		hdChromaSlot <= 1'b0;
		i_acpw_host_model.regWr(8'h10, 8'h13);
		tick(6);
		check("ovfPin", mfOut[1], 1'b0);
		pkt.delete();
		for (int i = 0; i < 12; i++)
			pkt.push_back(10'h100 + 10'(i));
		i_acpw_host_model.anc(pkt);
		i_acpw_host_model.flush();
		tick(6);
		check("ovfPin", mfOut[1], 1'b1);
		check("ovfPinOe", mfOe[1], 1'b1);
		hdChromaSlot <= 1'b1;
		tick(100);
		// Eight kept words: one whole packet, then two of the next.
		check("ancCount", got.size(), 16'h000E);
		check("ancLast", got[13], 10'h107);
		got.delete();
		$display("test anc_overflow done");
		conclude();
	end
endmodule
`default_nettype wire
